// >>> hw/pcsu_sequencer.sv
/*
 * Program counter, bank bit, return stack control, table read path and
 * counter snapshot registers of an 8-bit core, with a classic Wishbone slave.
 * Assumes the execute core reports one finished instruction per accepted
 * cycle and a program memory that returns data one cycle after the address.
 */
// The implementer's own choices: the Wishbone slave port and the address map.
// Operation
// - counter steps by one per instruction unless control jumps elsewhere
// - top fetch address bit comes from the bank select bit
// - only the counter low byte is reachable by software
// - jump, call, interrupt and reset load a target instead
// - taken skip discards prefetched word and inserts a dummy cycle
// - counter low byte write jumps within the page with dummy cycle
// - snapshot low read returns low byte and buffers high byte
// - snapshot high returns the buffer filled by the previous low read
// - snapshot high holds address bits 13..8, bits 7..6 zero, read-only
// - sixteen-level return stack holds counter values, not software visible
// - call and interrupt acknowledge push counter at stack index
// - both return kinds reload the counter from the stack
// - reset sets stack index to zero
// - full stack holds interrupt pending until a return frees a level
// - call on full stack still proceeds, oldest entry lost
// - index is read-only bits 3..0, increments, wraps 15 to 0
// - return decrements index modulo sixteen
// - ALU result flags update the status register
// - program memory is 16K words of 16 bits addressed by counter
// - execution starts at address zero after reset
// - table read address comes from table pointer low and high
// - short table form targets sector zero, far form any sector
// - table low byte to destination, high byte to table-high register
// - counter-changing instructions take one extra cycle
// - every table read takes two extra cycles
`timescale 1ns/1ps
module pcsu_sequencer #(
    parameter int SECTOR_W = 3
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [pcsu_pkg::BADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [pcsu_pkg::BUS_W-1:0] dat_i,
    output logic ack_o,
    output logic [pcsu_pkg::BUS_W-1:0] dat_o,
    input wire logic execValid,
    input wire pcsu_pkg::pcsu_op_t execOp,
    input wire logic [pcsu_pkg::PC_W-1:0] jumpTarget,
    input wire logic [7:0] execDestReg,
    input wire logic [SECTOR_W-1:0] execDestSector,
    input wire logic intReq,
    input wire logic [pcsu_pkg::PC_W-1:0] intVector,
    input wire logic aluFlagsValid,
    input wire logic [pcsu_pkg::STATUS_W-1:0] aluFlags,
    input wire logic [pcsu_pkg::WORD_W-1:0] pmData,
    output logic [pcsu_pkg::ADDR_W-1:0] pmAddr,
    output logic coreReady,
    output logic fetchFlush,
    output logic intAck,
    output logic tableValid,
    output logic [7:0] tableLowByte,
    output logic [7:0] tableDestReg,
    output logic [SECTOR_W-1:0] tableDestSector,
    output logic [pcsu_pkg::STATUS_W-1:0] statusFlags
);
    import pcsu_pkg::*;

    // ==========================================================
    // State
    pcsu_state_t state;
    pcsu_state_t next_state;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] next_pc;
    logic bank;
    logic next_bank;
    logic [PTR_W-1:0] stackPtr;
    logic [PTR_W-1:0] next_stackPtr;
    logic [DEPTH_W-1:0] stackDepth;
    logic [DEPTH_W-1:0] next_stackDepth;
    logic intPending;
    logic [7:0] tblLow;
    logic [5:0] tblHigh;
    logic [7:0] tableHigh;
    logic [7:0] snapHighBuf;
    logic push;
    logic pop;
    logic [ADDR_W-1:0] pushData;
    logic flushNow;
    logic ackNow;

    pcsu_stack_if #(.DATA_W(ADDR_W), .PTR_W(PTR_W)) stackPort ();

    pcsu_stack_mem #(.DATA_W(ADDR_W), .PTR_W(PTR_W)) stackMem (
        .clk(clk),
        .arst_n(arst_n),
        .port(stackPort.mem)
    );

    // ==========================================================
    // Bus decode
    wire selCounterLow = adr_i == ADR_COUNTER_LOW;
    wire selSnapLow = adr_i == ADR_SNAP_LOW;
    wire selSnapHigh = adr_i == ADR_SNAP_HIGH;
    wire selStackIndex = adr_i == ADR_STACK_INDEX;
    wire selBank = adr_i == ADR_BANK;
    wire selTblLow = adr_i == ADR_TBL_LOW;
    wire selTblHigh = adr_i == ADR_TBL_HIGH;
    wire selTableHigh = adr_i == ADR_TABLE_HIGH;
    wire selStatus = adr_i == ADR_STATUS;
    wire busReq = cyc_i && stb_i && !ack_o;
    wire byteWrite = we_i && sel_i[0];
    wire pclReq = busReq && byteWrite && selCounterLow;
    wire execTake = execValid && coreReady && (state == ST_RUN);
    // A counter low write waits for a slot with no instruction in flight
    wire pclFree = (state == ST_RUN) && !execTake;
    wire busTake = busReq && (!pclReq || pclFree);
    wire regWrite = busTake && byteWrite;
    wire pclWrite = regWrite && selCounterLow;
    wire pclPend = pclReq && !pclFree;
    wire snapRead = busTake && !we_i && selSnapLow;
    wire [7:0] wrByte = dat_i[7:0];

    // Only the low byte of the counter is on the map; the stack never is
    wire [7:0] readByte =
        selCounterLow ? pc[7:0] :
        selSnapLow ? pc[7:0] :
        selSnapHigh ? {2'b00, snapHighBuf[5:0] & SNAP_HIGH_MASK} :
        selStackIndex ? {4'h0, stackPtr} :
        selBank ? {7'h00, bank} :
        selTblLow ? tblLow :
        selTblHigh ? {2'b00, tblHigh} :
        selTableHigh ? tableHigh :
        selStatus ? statusFlags : BYTE_RESET;

    // ==========================================================
    // Stack helpers
    wire stackFull = stackDepth == DEPTH_FULL;
    wire [ADDR_W-1:0] tableAddr = {tblHigh, tblLow};
    wire [PC_W-1:0] pcInc = pc + 1'b1;
    wire isTable = (execOp == OP_TABLE) || (execOp == OP_FAR_TABLE);

    assign stackPort.wrEn = push;
    assign stackPort.wrAddr = stackPtr;
    assign stackPort.wrData = pushData;
    assign stackPort.rdAddr = next_stackPtr - 1'b1;

    // ==========================================================
    // Sequencing
    always_comb begin
        next_state = state;
        next_pc = pc;
        next_bank = (regWrite && selBank) ? wrByte[0] : bank;
        push = 1'b0;
        pop = 1'b0;
        pushData = {bank, pcInc};
        flushNow = 1'b0;
        ackNow = 1'b0;
        case (state)
            ST_RUN: begin
                if (pclWrite) begin
                    next_pc = {pc[PC_W-1:8], wrByte};
                    flushNow = 1'b1;
                    next_state = ST_DUMMY;
                end else if (execTake) begin
                    case (execOp)
                        OP_NEXT: begin
                            next_pc = pcInc;
                        end
                        OP_SKIP: begin
                            next_pc = pc + SKIP_STEP;
                            flushNow = 1'b1;
                            next_state = ST_DUMMY;
                        end
                        OP_JUMP: begin
                            next_pc = jumpTarget;
                            flushNow = 1'b1;
                            next_state = ST_DUMMY;
                        end
                        OP_CALL: begin
                            push = 1'b1;
                            next_pc = jumpTarget;
                            flushNow = 1'b1;
                            next_state = ST_DUMMY;
                        end
                        OP_RET, OP_INTERRUPT_EXIT_OP: begin
                            pop = 1'b1;
                            {next_bank, next_pc} = stackPort.rdData;
                            flushNow = 1'b1;
                            next_state = ST_DUMMY;
                        end
                        default: begin
                            next_pc = pcInc;
                            next_state = ST_TBL_WAIT;
                        end
                    endcase
                end else if (intPending && !stackFull) begin
                    next_state = ST_INTACK;
                end
            end
            ST_DUMMY: begin
                next_state = ST_RUN;
            end
            ST_TBL_WAIT: begin
                next_state = ST_TBL_CAP;
            end
            ST_TBL_CAP: begin
                next_state = ST_RUN;
            end
            ST_INTACK: begin
                // No call or return runs in the cycle before this state, so the stack is still not full here
                if (!stackFull) begin
                    push = 1'b1;
                    pushData = {bank, pc};
                    next_pc = intVector;
                    flushNow = 1'b1;
                    ackNow = 1'b1;
                    next_state = ST_DUMMY;
                end else begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    // Pointer wraps both ways; depth saturates so overflow keeps going
    always_comb begin
        next_stackPtr = stackPtr;
        next_stackDepth = stackDepth;
        if (push) begin
            next_stackPtr = stackPtr + 1'b1;
            next_stackDepth = stackFull ? DEPTH_FULL : stackDepth + 1'b1;
        end else if (pop) begin
            next_stackPtr = stackPtr - 1'b1;
            next_stackDepth = (stackDepth == DEPTH_EMPTY) ? DEPTH_EMPTY : stackDepth - 1'b1;
        end
    end

    wire [ADDR_W-1:0] next_pmAddr =
        (next_state == ST_TBL_WAIT) ? tableAddr : {next_bank, next_pc};
    wire next_coreReady = (next_state == ST_RUN) && !pclPend;

    // ==========================================================
    // Core-side registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_RUN;
            pc <= PC_RESET;
            bank <= RESET_BANK;
            pmAddr <= {RESET_BANK, PC_RESET};
            coreReady <= 1'b0;
            fetchFlush <= 1'b0;
            intAck <= 1'b0;
        end else begin
            state <= next_state;
            pc <= next_pc;
            bank <= next_bank;
            pmAddr <= next_pmAddr;
            coreReady <= next_coreReady;
            fetchFlush <= flushNow;
            intAck <= ackNow;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stackPtr <= PTR_RESET;
            stackDepth <= DEPTH_EMPTY;
            intPending <= 1'b0;
        end else begin
            stackPtr <= next_stackPtr;
            stackDepth <= next_stackDepth;
            intPending <= intReq || (intPending && !ackNow);
        end
    end

    // ==========================================================
    // Table read path
    wire tableCap = state == ST_TBL_CAP;
    wire tableStart = execTake && isTable && !pclWrite;
    // Short form can only name sector zero
    wire [SECTOR_W-1:0] destSector =
        (execOp == OP_FAR_TABLE) ? execDestSector : '0;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tableValid <= 1'b0;
            tableLowByte <= BYTE_RESET;
            tableDestReg <= BYTE_RESET;
            tableDestSector <= '0;
        end else begin
            tableValid <= tableCap;
            if (tableCap) begin
                tableLowByte <= pmData[7:0];
            end
            if (tableStart) begin
                tableDestReg <= execDestReg;
                tableDestSector <= destSector;
            end
        end
    end

    // ==========================================================
    // Software registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tblLow <= BYTE_RESET;
            tblHigh <= '0;
            tableHigh <= BYTE_RESET;
            statusFlags <= '0;
            snapHighBuf <= BYTE_RESET;
        end else begin
            if (regWrite && selTblLow) begin
                tblLow <= wrByte;
            end
            if (regWrite && selTblHigh) begin
                tblHigh <= wrByte[5:0];
            end
            // Hardware capture wins over a software write in the same cycle
            if (tableCap) begin
                tableHigh <= pmData[15:8];
            end else if (regWrite && selTableHigh) begin
                tableHigh <= wrByte;
            end
            if (aluFlagsValid) begin
                statusFlags <= aluFlags;
            end else if (regWrite && selStatus) begin
                statusFlags <= wrByte;
            end
            if (snapRead) begin
                snapHighBuf <= {2'b00, bank, pc[PC_W-1:8]};
            end
        end
    end

    // ==========================================================
    // Bus answer: one wait state, more for a counter low write held back by a busy core; unmapped reads give zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_o <= 1'b0;
            dat_o <= '0;
        end else begin
            ack_o <= busTake;
            if (busTake && !we_i) begin
                dat_o <= {24'h000000, readByte};
            end
        end
    end

endmodule : pcsu_sequencer

// >>> hw/pcsu_pkg.sv
/*
 * Shared constants and types of the program counter and return stack unit.
 * Assumes a 32-bit classic Wishbone register port with byte addresses.
 */
package pcsu_pkg;

    // ==========================================================
    // Widths
    localparam int PC_W = 13;
    localparam int ADDR_W = 14;
    localparam int WORD_W = 16;
    localparam int PTR_W = 4;
    localparam int DEPTH_W = 5;
    localparam int STATUS_W = 8;
    localparam int BUS_W = 32;
    localparam int BADR_W = 8;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [BADR_W-1:0] ADR_COUNTER_LOW = 8'h00;
    localparam logic [BADR_W-1:0] ADR_SNAP_LOW = 8'h04;
    localparam logic [BADR_W-1:0] ADR_SNAP_HIGH = 8'h08;
    localparam logic [BADR_W-1:0] ADR_STACK_INDEX = 8'h0c;
    localparam logic [BADR_W-1:0] ADR_BANK = 8'h10;
    localparam logic [BADR_W-1:0] ADR_TBL_LOW = 8'h14;
    localparam logic [BADR_W-1:0] ADR_TBL_HIGH = 8'h18;
    localparam logic [BADR_W-1:0] ADR_TABLE_HIGH = 8'h1c;
    localparam logic [BADR_W-1:0] ADR_STATUS = 8'h20;

    // ==========================================================
    // Values after reset and counts
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic RESET_BANK = 1'b0;
    localparam logic [PTR_W-1:0] PTR_RESET = 4'h0;
    localparam logic [DEPTH_W-1:0] DEPTH_EMPTY = 5'h00;
    localparam logic [DEPTH_W-1:0] DEPTH_FULL = 5'h10;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [5:0] SNAP_HIGH_MASK = 6'h3f;
    localparam logic [PC_W-1:0] SKIP_STEP = 13'h0002;

    // ==========================================================
    // Operations reported by the execute core
    typedef enum logic [2:0] {
        OP_NEXT, OP_SKIP, OP_JUMP, OP_CALL,
        OP_RET, OP_INTERRUPT_EXIT_OP, OP_TABLE, OP_FAR_TABLE
    } pcsu_op_t;

    typedef enum logic [2:0] {
        ST_RUN, ST_DUMMY, ST_TBL_WAIT, ST_TBL_CAP, ST_INTACK
    } pcsu_state_t;

endpackage : pcsu_pkg

// >>> hw/pcsu_stack_if.sv
/*
 * Port bundle between the sequencer and its return stack memory.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/1ps
interface pcsu_stack_if #(
    parameter int DATA_W = 14,
    parameter int PTR_W = 4
);
    logic wrEn;
    logic [PTR_W-1:0] wrAddr;
    logic [DATA_W-1:0] wrData;
    logic [PTR_W-1:0] rdAddr;
    logic [DATA_W-1:0] rdData;

    modport ctrl(output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
    modport mem(input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface : pcsu_stack_if

// >>> hw/pcsu_stack_mem.sv
/*
 * Return stack storage: one write port, registered read port.
 * Assumes the controller presents the next top-of-stack address each cycle.
 */
`timescale 1ns/1ps
module pcsu_stack_mem #(
    parameter int DATA_W = 14,
    parameter int PTR_W = 4
) (
    input wire logic clk,
    input wire logic arst_n,
    pcsu_stack_if.mem port
);
    // ==========================================================
    // Storage
    logic [DATA_W-1:0] cells [2**PTR_W];
    wire forward = port.wrEn && (port.wrAddr == port.rdAddr);

    always_ff @(posedge clk) begin
        if (port.wrEn) begin
            cells[port.wrAddr] <= port.wrData;
        end
    end

    // Write-first so a pop right after a push sees the new top
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            port.rdData <= '0;
        end else begin
            port.rdData <= forward ? port.wrData : cells[port.rdAddr];
        end
    end
endmodule : pcsu_stack_mem

// >>> verif/pcsu_pm_model.sv
/* Program memory model for the sequencer bench.
   Assumes pmAddr from the sequencer and a one-cycle read latency. */
`timescale 1ns/1ps
module pcsu_pm_model (
    input wire logic clk,
    input wire logic [13:0] pmAddr,
    output logic [15:0] pmData
);
    // ==========================================================
    // Read port
    // Word built from its address so every location differs
    always_ff @(posedge clk) begin
        pmData <= {pmAddr[7:0], 2'b01, pmAddr[13:8]};
    end
endmodule : pcsu_pm_model

// >>> verif/pcsu_sequencer_assertions.sv
/* Concurrent checks on the sequencer ports.
   Assumes binding to pcsu_sequencer; one clock domain. */
`timescale 1ns/1ps
module pcsu_sequencer_assertions
    import pcsu_pkg::*;
#(
    parameter int SECTOR_W = 3
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic ack_o,
    input wire logic [31:0] dat_o,
    input wire logic execValid,
    input wire pcsu_pkg::pcsu_op_t execOp,
    input wire logic [12:0] jumpTarget,
    input wire logic [15:0] pmData,
    input wire logic [13:0] pmAddr,
    input wire logic coreReady,
    input wire logic fetchFlush,
    input wire logic intAck,
    input wire logic tableValid,
    input wire logic [7:0] tableLowByte,
    input wire logic [SECTOR_W-1:0] tableDestSector
);
    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire taken = execValid && coreReady;
    chk_next_step: assert property (
        taken && execOp == OP_NEXT |=> pmAddr[12:0] == $past(pmAddr[12:0]) + 13'h1)
        else $error("counter did not step by one");
    chk_jump_load: assert property (
        taken && execOp == OP_JUMP |=> pmAddr == {$past(pmAddr[13]), $past(jumpTarget)})
        else $error("jump target not loaded");
    chk_branch_dummy: assert property (
        taken && execOp inside {OP_SKIP, OP_JUMP, OP_CALL, OP_RET, OP_INTERRUPT_EXIT_OP}
        |=> fetchFlush && !coreReady ##1 coreReady && !fetchFlush)
        else $error("branch dummy cycle wrong");
    chk_table_two: assert property (
        taken && execOp inside {OP_TABLE, OP_FAR_TABLE}
        |=> !coreReady [*2] ##1 tableValid && coreReady)
        else $error("table read not two cycles");
    chk_table_low: assert property (
        tableValid |-> tableLowByte == $past(pmData[7:0]))
        else $error("table low byte wrong");
    chk_short_sector: assert property (
        taken && execOp == OP_TABLE |-> ##3 tableDestSector == '0)
        else $error("short table sector not zero");
    chk_int_flush: assert property (
        intAck |-> fetchFlush ##1 !intAck)
        else $error("acknowledge without flush");
    chk_snap_high: assert property (
        ack_o && $past(adr_i) == ADR_SNAP_HIGH && !$past(we_i) |-> dat_o[31:6] == '0)
        else $error("snapshot high upper bits set");
    chk_index_bits: assert property (
        ack_o && $past(adr_i) == ADR_STACK_INDEX && !$past(we_i) |-> dat_o[31:4] == '0)
        else $error("stack index upper bits set");
    chk_read_ack: assert property (
        cyc_i && stb_i && !we_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("read not acked in one cycle");
endmodule : pcsu_sequencer_assertions

// >>> verif/tb_pcsu_sequencer.sv
/* Self-checking bench of the sequencer with a program memory model.
   Assumes the checker module and pcsu_pkg are compiled first. */
`timescale 1ns/1ps
module tb_pcsu_sequencer;
    import pcsu_pkg::*;
    logic clk, arst_n, cyc, stb, we, ack, execValid, intReq, aluValid;
    logic coreReady, fetchFlush, intAck, tableValid, bank;
    logic [7:0] adr, destReg, tblLow, tblDest, aluFlags, status;
    logic [3:0] sel, idx;
    logic [31:0] wdat, rdat, r, q;
    logic [2:0] destSec, tblSec;
    logic [12:0] target, vector, pc;
    logic [12:0] stk [16];
    logic [15:0] pmData, w;
    logic [13:0] pmAddr;
    pcsu_op_t op;
    int errors = 0, num_checks = 0, i, n;
    integer seed = 32'hf7a0bf36;

    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end

    pcsu_sequencer dut (.clk(clk), .arst_n(arst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .ack_o(ack), .dat_o(rdat),
        .execValid(execValid), .execOp(op), .jumpTarget(target), .execDestReg(destReg),
        .execDestSector(destSec), .intReq(intReq), .intVector(vector),
        .aluFlagsValid(aluValid), .aluFlags(aluFlags), .pmData(pmData), .pmAddr(pmAddr),
        .coreReady(coreReady), .fetchFlush(fetchFlush), .intAck(intAck),
        .tableValid(tableValid), .tableLowByte(tblLow), .tableDestReg(tblDest),
        .tableDestSector(tblSec), .statusFlags(status));
    pcsu_pm_model pm (.clk(clk), .pmAddr(pmAddr), .pmData(pmData));

    // ==========================================================
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Program memory word as the model lays it out
    function automatic logic [15:0] pm_word(input logic [13:0] a);
        return {a[7:0], 2'b01, a[13:8]};
    endfunction : pm_word

    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    // Bounded wait step; a hang counts as a mismatch
    task automatic tick(inout int c);
        c++;
        if (c > 64) begin
            errors++;
            $display("Error at %0t: wait timed out", $time);
            stop_test();
        end
        @(posedge clk);
    endtask : tick

    task automatic wb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int c;
        c = 0;
        cyc <= 1;
        stb <= 1;
        we <= wr;
        adr <= a;
        sel <= 4'hf;
        wdat <= {24'h0, d};
        @(posedge clk);
        while (ack !== 1'b1) tick(c);
        q = rdat;
        cyc <= 0;
        stb <= 0;
        @(posedge clk);
    endtask : wb

    // Issues one instruction and updates the bench model of counter and stack
    task automatic ex(input pcsu_op_t o, input logic [12:0] t);
        int c;
        c = 0;
        execValid <= 1;
        op <= o;
        target <= t;
        destReg <= $random(seed);
        destSec <= $random(seed);
        @(posedge clk);
        while (coreReady !== 1'b1) tick(c);
        execValid <= 0;
        @(posedge clk);
        case (o)
            OP_NEXT: pc = pc + 13'h1;
            OP_SKIP: pc = pc + SKIP_STEP;
            OP_JUMP: pc = t;
            OP_CALL: begin
                stk[idx] = pc + 13'h1;
                idx++;
                pc = t;
            end
            OP_RET, OP_INTERRUPT_EXIT_OP: begin
                idx--;
                pc = stk[idx];
            end
            // Table reads step past themselves like any plain instruction
            default: pc = pc + 13'h1;
        endcase
    endtask : ex

    task automatic chk_state;
        wb(0, ADR_SNAP_LOW, 0);
        chk(q, {24'h0, pc[7:0]});
        wb(0, ADR_SNAP_HIGH, 0);
        chk(q, {26'h0, bank, pc[12:8]});
        wb(0, ADR_STACK_INDEX, 0);
        chk(q, {28'h0, idx});
    endtask : chk_state

    // ==========================================================
    // Scenarios
    initial begin
        {arst_n, cyc, stb, we, execValid, intReq, aluValid} = '0;
        {adr, sel, wdat, target, destReg, destSec, aluFlags} = '0;
        op = OP_NEXT;
        r = $random(seed);
        vector = r[12:0];
        {pc, idx, bank} = '0;
        repeat (20) @(posedge clk);
        arst_n <= 1;
        @(posedge clk);
        chk_state();
        wb(0, 8'h24, 0);
        chk(q, 32'h0);
        $display("reset test done");
        wb(1, ADR_BANK, 8'h01);
        bank = 1;
        wb(0, ADR_BANK, 0);
        chk(q, 32'h1);
        r = $random(seed);
        ex(OP_JUMP, r[12:0]);
        repeat (r[15:13] + 2) ex(OP_NEXT, 0);
        ex(OP_SKIP, 0);
        wb(1, ADR_SNAP_HIGH, 8'hff);
        chk_state();
        r = $random(seed);
        wb(1, ADR_COUNTER_LOW, r[7:0]);
        pc[7:0] = r[7:0];
        chk_state();
        wb(0, ADR_COUNTER_LOW, 0);
        chk(q, {24'h0, r[7:0]});
        $display("counter test done");
        for (i = 0; i < 17; i++) begin
            r = $random(seed);
            ex(OP_CALL, r[12:0]);
            chk_state();
        end
        for (i = 0; i < 16; i++) begin
            ex(i[0] ? OP_INTERRUPT_EXIT_OP : OP_RET, 0);
            chk_state();
        end
        $display("stack test done");
        for (i = 0; i < 16; i++) begin
            r = $random(seed);
            ex(OP_CALL, r[12:0]);
        end
        intReq <= 1;
        @(posedge clk);
        intReq <= 0;
        repeat (10) begin
            @(posedge clk);
            chk(intAck, 0);
        end
        ex(OP_RET, 0);
        n = 0;
        while (intAck !== 1'b1) tick(n);
        stk[idx] = pc;
        idx++;
        pc = vector;
        repeat (3) @(posedge clk);
        chk_state();
        ex(OP_INTERRUPT_EXIT_OP, 0);
        chk_state();
        $display("interrupt test done");
        for (i = 0; i < 4; i++) begin
            r = $random(seed);
            wb(1, ADR_TBL_LOW, r[7:0]);
            wb(1, ADR_TBL_HIGH, r[15:8]);
            ex(i[0] ? OP_FAR_TABLE : OP_TABLE, 0);
            n = 0;
            while (tableValid !== 1'b1) tick(n);
            w = pm_word({r[13:8], r[7:0]});
            chk(tblLow, w[7:0]);
            chk(tblDest, destReg);
            chk(tblSec, i[0] ? destSec : 3'h0);
            wb(0, ADR_TABLE_HIGH, 0);
            chk(q, {24'h0, w[15:8]});
        end
        $display("table test done");
        r = $random(seed);
        aluValid <= 1;
        aluFlags <= r[7:0];
        @(posedge clk);
        aluValid <= 0;
        @(posedge clk);
        chk(status, r[7:0]);
        $display("status test done");
        // Reset again with a live stack, counter and bank
        r = $random(seed);
        ex(OP_CALL, r[12:0]);
        arst_n <= 0;
        @(posedge clk);
        arst_n <= 1;
        {pc, idx, bank} = '0;
        @(posedge clk);
        chk_state();
        $display("second reset test done");
        stop_test();
    end
endmodule : tb_pcsu_sequencer

bind pcsu_sequencer pcsu_sequencer_assertions #(.SECTOR_W(SECTOR_W)) u_chk (.clk(clk),
    .arst_n(arst_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .ack_o(ack_o), .dat_o(dat_o), .execValid(execValid), .execOp(execOp),
    .jumpTarget(jumpTarget), .pmData(pmData), .pmAddr(pmAddr), .coreReady(coreReady),
    .fetchFlush(fetchFlush), .intAck(intAck), .tableValid(tableValid),
    .tableLowByte(tableLowByte), .tableDestSector(tableDestSector));
